// >>> common/dsc_pkg.sv
// Shared constants and types for the dual converter conversion control.
// Assumes the control logic runs on the on-chip oscillator clock and the read path on the host serial clock.
package dsc_pkg;

	// ----------------------------------------------------------------
	// Result format
	// ----------------------------------------------------------------
	localparam int          NUM_CONV      = 2;
	localparam int          RES_W         = 14;
	localparam logic [3:0]  BITS_LARGE    = 4'hE;
	localparam logic [3:0]  BITS_SMALL    = 4'hC;
	localparam logic [3:0]  SAR_TOP_IDX   = 4'hD;
	localparam logic [3:0]  STOP_LARGE    = 4'h0;
	localparam logic [3:0]  STOP_SMALL    = 4'h2;
	localparam logic [13:0] SIGN_FLIP     = 14'h2000;
	localparam logic [13:0] CODE_RESET    = 14'h0000;

	// ----------------------------------------------------------------
	// Reset values and forbidden span code of the static selections
	// ----------------------------------------------------------------
	localparam logic        CH_PAIR_RESET = 1'h0;
	localparam logic [1:0]  SPAN_RESET    = 2'h0;
	localparam logic [1:0]  SPAN_FORBID   = 2'h3;
	localparam logic        REF_RESET     = 1'h1;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DSC_IDLE,
		DSC_CONVERT,
		DSC_SLEEP
	} dsc_state_t;

endpackage

// >>> core/dsc_conv_ctrl.sv
// Conversion sequencer and serial read path of a dual simultaneous-sampling converter.
// Assumes ref_clk_in is the on-chip oscillator and link_sclk_in is the host clock, which may stop between frames.
//
// Functional notes
// - Conversion start falling edge holds both inputs and starts both converters together.
// - Busy rises when conversions begin and stays high throughout them.
// - Approximation steps run on the internal oscillator, never the serial clock.
// - Busy falls when both conversions have completed.
// - Busy falling returns both track-and-holds to tracking.
// - The two results leave on two separate serial data pins.
// - Results are 12 bits on the small variant, 14 on the large.
// - Results are twos complement.
// - Reference select high uses internal reference, low uses external reference.
// - Two inputs per converter; span select bits choose the input range.
// - Start still low at conversion end powers down; its rising edge wakes.
// - Chip select low enables outputs and presents both results.
// - Channel pair select latched at busy rise, used by the next conversion.
`timescale 1ns/1ps
`default_nettype none

module dsc_conv_ctrl #(
	parameter bit LARGE_VARIANT = 1'b1
) (
	input  wire logic        ref_clk_in,
	input  wire logic        reset_in,
	input  wire logic        link_sclk_in,
	input  wire logic        chip_select_n_in,
	input  wire logic        conversion_start_n_in,
	input  wire logic        reference_source_select_in,
	input  wire logic        input_span_select_lo_in,
	input  wire logic        input_span_select_hi_in,
	input  wire logic        channel_pair_select_in,
	input  wire logic [13:0] level_a1_in,
	input  wire logic [13:0] level_a2_in,
	input  wire logic [13:0] level_b1_in,
	input  wire logic [13:0] level_b2_in,
	output logic             busy_out,
	output logic             hold_a_out,
	output logic             hold_b_out,
	output logic             powered_down_out,
	output logic             internal_ref_enable_out,
	output logic [1:0]       span_select_out,
	output logic             channel_pair_out,
	output logic             result_oe_out,
	output logic             result_out_a_out,
	output logic             result_out_b_out
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] cnv_sync_r;
	logic [1:0] cs_sync_r;
	logic [1:0] ref_sync_r;
	logic [1:0] span_lo_sync_r;
	logic [1:0] span_hi_sync_r;
	logic [1:0] pair_sync_r;

	// The third stage of the start line only feeds the edge detector.
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			cnv_sync_r <= 3'h7;
			cs_sync_r  <= 2'h3;
		end else begin
			cnv_sync_r <= {cnv_sync_r[1:0], conversion_start_n_in};
			cs_sync_r  <= {cs_sync_r[0], chip_select_n_in};
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			ref_sync_r     <= {2{dsc_pkg::REF_RESET}};
			span_lo_sync_r <= 2'h0;
			span_hi_sync_r <= 2'h0;
			pair_sync_r    <= {2{dsc_pkg::CH_PAIR_RESET}};
		end else begin
			ref_sync_r     <= {ref_sync_r[0], reference_source_select_in};
			span_lo_sync_r <= {span_lo_sync_r[0], input_span_select_lo_in};
			span_hi_sync_r <= {span_hi_sync_r[0], input_span_select_hi_in};
			pair_sync_r    <= {pair_sync_r[0], channel_pair_select_in};
		end
	end

	logic start_fall;
	logic start_rise;
	logic start_low;

	assign start_low  = ~cnv_sync_r[1];
	assign start_fall = cnv_sync_r[2] & ~cnv_sync_r[1];
	assign start_rise = ~cnv_sync_r[2] & cnv_sync_r[1];

	// ----------------------------------------------------------------
	// Analog level synchronisers, one per input channel
	// ----------------------------------------------------------------
	// Levels come from the front end on their own timing; each word passes two stages.
	// Both stages sample the word on every oscillator cycle with no enable, so a word torn in flight can reach a result.
	logic [13:0] level_raw [4];
	logic [13:0] level_s1_r [4];
	logic [13:0] level_s2_r [4];

	assign level_raw[0] = level_a1_in;
	assign level_raw[1] = level_a2_in;
	assign level_raw[2] = level_b1_in;
	assign level_raw[3] = level_b2_in;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_level_sync
			always_ff @(posedge ref_clk_in) begin
				if (reset_in) begin
					level_s1_r[gi] <= dsc_pkg::CODE_RESET;
					level_s2_r[gi] <= dsc_pkg::CODE_RESET;
				end else begin
					level_s1_r[gi] <= level_raw[gi];
					level_s2_r[gi] <= level_s1_r[gi];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------
	dsc_pkg::dsc_state_t state_r;
	logic                start_r;
	logic                busy_r;
	logic                hold_r;
	logic                sleep_r;
	logic [1:0]          conv_done;
	logic                all_done;

	assign all_done = &conv_done;

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			state_r <= dsc_pkg::DSC_IDLE;
			start_r <= 1'b0;
		end else begin
			start_r <= 1'b0;
			case (state_r)
				dsc_pkg::DSC_IDLE: begin
					if (start_fall) begin
						start_r <= 1'b1;
						state_r <= dsc_pkg::DSC_CONVERT;
					end
				end
				dsc_pkg::DSC_CONVERT: begin
					// Further start edges are not looked at until the results are in.
					if (all_done) begin
						state_r <= start_low ? dsc_pkg::DSC_SLEEP : dsc_pkg::DSC_IDLE;
					end
				end
				dsc_pkg::DSC_SLEEP: begin
					if (start_rise) begin
						state_r <= dsc_pkg::DSC_IDLE;
					end
				end
				default: begin
					state_r <= dsc_pkg::DSC_IDLE;
				end
			endcase
		end
	end

	// Busy and hold move together: up with the start, down with the last result.
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			busy_r <= 1'b0;
			hold_r <= 1'b0;
		end else if (state_r == dsc_pkg::DSC_IDLE && start_fall) begin
			busy_r <= 1'b1;
			hold_r <= 1'b1;
		end else if (state_r == dsc_pkg::DSC_CONVERT && all_done) begin
			busy_r <= 1'b0;
			hold_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			sleep_r <= 1'b0;
		end else if (state_r == dsc_pkg::DSC_CONVERT && all_done) begin
			sleep_r <= start_low;
		end else if (state_r == dsc_pkg::DSC_SLEEP && start_rise) begin
			sleep_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Channel pair, span and reference selection
	// ----------------------------------------------------------------
	// The pair sampled at busy rise steers the next conversion, not the one now starting.
	logic pair_r;
	logic conv_pair_r;
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			pair_r      <= dsc_pkg::CH_PAIR_RESET;
			conv_pair_r <= dsc_pkg::CH_PAIR_RESET;
		end else if (state_r == dsc_pkg::DSC_IDLE && start_fall) begin
			pair_r      <= pair_sync_r[1];
			conv_pair_r <= pair_r;
		end
	end

	// The span is frozen while converting; the forbidden code keeps the previous span.
	logic [1:0] span_r;
	logic [1:0] span_req;
	assign span_req = {span_hi_sync_r[1], span_lo_sync_r[1]};

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			span_r <= dsc_pkg::SPAN_RESET;
		end else if (!busy_r && span_req != dsc_pkg::SPAN_FORBID) begin
			span_r <= span_req;
		end
	end

	logic ref_int_r;
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			ref_int_r <= dsc_pkg::REF_RESET;
		end else begin
			ref_int_r <= ref_sync_r[1];
		end
	end

	// ----------------------------------------------------------------
	// Converters
	// ----------------------------------------------------------------
	logic [13:0] conv_code [dsc_pkg::NUM_CONV];
	logic [13:0] conv_level [dsc_pkg::NUM_CONV];

	generate
		for (gi = 0; gi < dsc_pkg::NUM_CONV; gi++) begin : g_conv
			// Both engines share one start pulse, so both sample in the same cycle.
			assign conv_level[gi] = conv_pair_r ? level_s2_r[2 * gi + 1] : level_s2_r[2 * gi];

			dsc_sar_engine u_engine (
				.clk_in   (ref_clk_in),
				.reset_in (reset_in),
				.start_in (start_r),
				.large_in (LARGE_VARIANT),
				.level_in (conv_level[gi]),
				.done_out (conv_done[gi]),
				.code_out (conv_code[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Status outputs
	// ----------------------------------------------------------------
	logic oe_r;
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			oe_r <= 1'b0;
		end else begin
			oe_r <= ~cs_sync_r[1];
		end
	end

	assign busy_out                = busy_r;
	assign hold_a_out              = hold_r;
	assign hold_b_out              = hold_r;
	assign powered_down_out        = sleep_r;
	assign internal_ref_enable_out = ref_int_r;
	assign span_select_out         = span_r;
	assign channel_pair_out        = pair_r;
	assign result_oe_out           = oe_r;

	// ----------------------------------------------------------------
	// Serial read path, host clock domain
	// ----------------------------------------------------------------
	// The result words are quasi-static here: the host clocks only after busy has fallen,
	// and the codes do not change again until the next conversion completes.
	// Chip select high ends the frame, since the host clock may not run outside it.
	localparam logic [3:0] RES_BITS = LARGE_VARIANT ? dsc_pkg::BITS_LARGE : dsc_pkg::BITS_SMALL;

	logic [3:0] bit_cnt_r;
	logic       dout_a_r;
	logic       dout_b_r;
	logic [3:0] bit_sel;

	assign bit_sel = dsc_pkg::SAR_TOP_IDX - bit_cnt_r;

	always_ff @(negedge link_sclk_in or posedge chip_select_n_in) begin
		if (chip_select_n_in) begin
			bit_cnt_r <= 4'h0;
			dout_a_r  <= 1'b0;
			dout_b_r  <= 1'b0;
		end else if (bit_cnt_r < RES_BITS) begin
			dout_a_r  <= conv_code[0][bit_sel];
			dout_b_r  <= conv_code[1][bit_sel];
			bit_cnt_r <= bit_cnt_r + 4'h1;
		end else begin
			dout_a_r <= 1'b0;
			dout_b_r <= 1'b0;
		end
	end

	assign result_out_a_out = dout_a_r;
	assign result_out_b_out = dout_b_r;

endmodule

`default_nettype wire

// >>> core/dsc_sar_engine.sv
// One successive-approximation engine: captures a held level and resolves it bit by bit.
// Assumes level_in is already in the oscillator domain and stable in the cycle start_in is high.
`timescale 1ns/1ps
`default_nettype none

module dsc_sar_engine (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic        start_in,
	input  wire logic        large_in,
	input  wire logic [13:0] level_in,
	output logic             done_out,
	output logic [13:0]      code_out
);

	// ----------------------------------------------------------------
	// Approximation state
	// ----------------------------------------------------------------
	logic [13:0] held_r;
	logic [13:0] trial_r;
	logic [3:0]  bit_idx_r;
	logic        run_r;
	logic [13:0] decided;
	logic [3:0]  stop_idx;

	assign stop_idx = large_in ? dsc_pkg::STOP_LARGE : dsc_pkg::STOP_SMALL;

	// The comparison runs in offset binary so an unsigned compare is correct.
	always_comb begin
		decided = trial_r;
		if (trial_r > held_r) begin
			decided[bit_idx_r] = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			held_r    <= dsc_pkg::CODE_RESET;
			trial_r   <= dsc_pkg::CODE_RESET;
			bit_idx_r <= dsc_pkg::SAR_TOP_IDX;
			run_r     <= 1'b0;
		end else if (start_in && !run_r) begin
			held_r    <= level_in ^ dsc_pkg::SIGN_FLIP;
			trial_r   <= dsc_pkg::SIGN_FLIP;
			bit_idx_r <= dsc_pkg::SAR_TOP_IDX;
			run_r     <= 1'b1;
		end else if (run_r) begin
			if (bit_idx_r > stop_idx) begin
				trial_r   <= decided | (14'h0001 << (bit_idx_r - 4'h1));
				bit_idx_r <= bit_idx_r - 4'h1;
			end else begin
				trial_r <= decided;
				run_r   <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Result and completion
	// ----------------------------------------------------------------
	// The code holds until the next completion so the serial side can read it at leisure.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			code_out <= dsc_pkg::CODE_RESET;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (run_r && !(bit_idx_r > stop_idx)) begin
				code_out <= decided ^ dsc_pkg::SIGN_FLIP;
				done_out <= 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// >>> sim/dsc_conv_ctrl_checker.sv
// Timing checks on the conversion sequencer ports.
// Assumes it is bound into the sequencer and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module dsc_conv_ctrl_checker #(
	parameter bit LARGE_VARIANT = 1'b1
) (
	input wire logic       ref_clk_in,
	input wire logic       reset_in,
	input wire logic       chip_select_n_in,
	input wire logic       conversion_start_n_in,
	input wire logic       reference_source_select_in,
	input wire logic       channel_pair_select_in,
	input wire logic       busy_out,
	input wire logic       hold_a_out,
	input wire logic       hold_b_out,
	input wire logic       powered_down_out,
	input wire logic       internal_ref_enable_out,
	input wire logic       channel_pair_out,
	input wire logic       result_oe_out,
	input wire logic       result_out_a_out,
	input wire logic       result_out_b_out
);
	localparam int BUSY_HI = LARGE_VARIANT ? 15 : 13;

	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);

	sequence s_idle_fall;
		!busy_out && !powered_down_out && $fell(conversion_start_n_in);
	endsequence
	sequence s_held;
		busy_out && hold_a_out && hold_b_out;
	endsequence

	a_start_holds: assert property (s_idle_fall |-> ##[2:4] s_held)
		else $error("start edge gave no conversion");
	a_busy_length: assert property ($rose(busy_out) |-> (busy_out throughout ##BUSY_HI 1'b1) ##1 !busy_out)
		else $error("busy length wrong");
	a_hold_tracks: assert property (hold_a_out == busy_out && hold_b_out == busy_out)
		else $error("hold differs from busy");
	a_sleep_entry: assert property ($fell(busy_out) && $past(conversion_start_n_in, 4) == conversion_start_n_in
		|-> powered_down_out == !conversion_start_n_in)
		else $error("power down entry wrong");
	a_wake_up: assert property (powered_down_out && $rose(conversion_start_n_in) |-> ##[2:5] !powered_down_out)
		else $error("no wake on start rise");
	a_sleep_quiet: assert property (powered_down_out |-> !busy_out)
		else $error("busy while powered down");
	a_pair_latch: assert property ($rose(busy_out) && $past(channel_pair_select_in, 3) == channel_pair_select_in
		|-> channel_pair_out == channel_pair_select_in)
		else $error("pair not latched at busy rise");
	a_ref_follow: assert property ($past(reference_source_select_in, 4) == reference_source_select_in
		|-> internal_ref_enable_out == reference_source_select_in)
		else $error("reference enable wrong");
	a_oe_follow: assert property ($past(chip_select_n_in, 4) == chip_select_n_in
		|-> result_oe_out == !chip_select_n_in)
		else $error("output enable wrong");
	a_idle_quiet: assert property (chip_select_n_in |-> !result_out_a_out && !result_out_b_out)
		else $error("data out while deselected");
endmodule

bind dsc_conv_ctrl dsc_conv_ctrl_checker #(.LARGE_VARIANT(LARGE_VARIANT)) i_dsc_conv_ctrl_checker (
	.ref_clk_in, .reset_in, .chip_select_n_in, .conversion_start_n_in, .reference_source_select_in,
	.channel_pair_select_in, .busy_out, .hold_a_out, .hold_b_out, .powered_down_out,
	.internal_ref_enable_out, .channel_pair_out, .result_oe_out, .result_out_a_out, .result_out_b_out
);

`default_nettype wire

// >>> sim/dsc_host_model.sv
// Host side of the serial read path: clocks one result pair out per request.
// Assumes data changes on falling link clock edges; the link clock stands high between frames.
`timescale 1ns/1ps
`default_nettype none

module dsc_host_model #(
	parameter int BITS = 14
) (
	input  wire logic   go_in,
	input  wire logic   busy_in,
	input  wire logic   result_out_a_in,
	input  wire logic   result_out_b_in,
	output logic        link_sclk_out,
	output logic        chip_select_n_out,
	output logic [13:0] word_a_out,
	output logic [13:0] word_b_out,
	output logic        done_out
);
	initial begin
		link_sclk_out = 1'b1;
		chip_select_n_out = 1'b0;
		done_out = 1'b0;
		// One deselect edge at power-up clears the data pins before the first frame.
		#10;
		chip_select_n_out = 1'b1;
	end

	// The link clock only runs inside a frame, so the converter must finish on its own clock.
	always @(posedge go_in) begin
		done_out = 1'b0;
		word_a_out = 14'h0000;
		word_b_out = 14'h0000;
		wait (busy_in === 1'b0);
		chip_select_n_out = 1'b0;
		// The odd lead keeps link edges away from the oscillator edges.
		#403;
		for (int i = 0; i < BITS; i++) begin
			link_sclk_out = 1'b0;
			#7.5;
			link_sclk_out = 1'b1;
			word_a_out = {word_a_out[12:0], result_out_a_in};
			word_b_out = {word_b_out[12:0], result_out_b_in};
			#7.5;
		end
		chip_select_n_out = 1'b1;
		done_out = 1'b1;
	end
endmodule

`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the dual converter sequencer with a host read model.
// Assumes the checker binds itself; all inputs except the host model's link clock and chip select change on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic        clk, rst, cs_n, sclk, go, done, start_n, rsel, slo, shi, pair, prev;
	logic        busy, hold_a, hold_b, pdn, iref, pout, poe, da, db;
	logic [1:0]  span, span_exp;
	logic [13:0] lv [4];
	logic [13:0] wa, wb;
	logic [13:0] tv [4] = '{14'h1FFF, 14'h2000, 14'h0000, 14'h0ABC};
	int          err_count, tests_run;

	dsc_conv_ctrl #(.LARGE_VARIANT(1'b1)) i_dsc_conv_ctrl (
		.ref_clk_in(clk), .reset_in(rst), .link_sclk_in(sclk), .chip_select_n_in(cs_n),
		.conversion_start_n_in(start_n), .reference_source_select_in(rsel),
		.input_span_select_lo_in(slo), .input_span_select_hi_in(shi), .channel_pair_select_in(pair),
		.level_a1_in(lv[0]), .level_a2_in(lv[1]), .level_b1_in(lv[2]), .level_b2_in(lv[3]),
		.busy_out(busy), .hold_a_out(hold_a), .hold_b_out(hold_b), .powered_down_out(pdn),
		.internal_ref_enable_out(iref), .span_select_out(span), .channel_pair_out(pout),
		.result_oe_out(poe), .result_out_a_out(da), .result_out_b_out(db));

	dsc_host_model #(.BITS(14)) i_dsc_host_model (
		.go_in(go), .busy_in(busy), .result_out_a_in(da), .result_out_b_in(db), .link_sclk_out(sclk),
		.chip_select_n_out(cs_n), .word_a_out(wa), .word_b_out(wb), .done_out(done));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic do_reset();
		rst = 1'b1;
		cyc(20);
		rst = 1'b0;
		cyc(1);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		chk({7'h00, iref, span, pout, busy, pdn, poe}, 14'h0040);
		$display("reset values done");
	endtask

	// Mode 1 retriggers during busy, mode 2 holds start low into power-down.
	task automatic conv(input int mode, input logic p, input logic [1:0] sp, input logic [13:0] ea,
		input logic [13:0] eb);
		int n;
		if (sp != 2'h3) span_exp = sp;
		pair = p;
		cyc(2);
		start_n = 1'b0;
		cyc(5);
		chk({13'h0000, busy & hold_a & hold_b}, 14'h0001);
		if (mode != 2) start_n = 1'b1;
		{shi, slo} = sp;
		if (mode == 1) begin
			cyc(2);
			start_n = 1'b0;
			cyc(2);
			start_n = 1'b1;
		end
		for (n = 0; n < 30 && busy !== 1'b0; n++) cyc(1);
		chk({12'h000, busy, hold_a}, 14'h0000);
		chk({13'h0000, pdn}, {13'h0000, mode == 2});
		cyc(5);
		start_n = 1'b1;
		cyc(5);
		chk({10'h000, busy, pdn, span}, {12'h000, span_exp});
		go = 1'b1;
		cyc(1);
		for (n = 0; n < 20 && done !== 1'b1; n++) cyc(1);
		go = 1'b0;
		chk(wa, ea);
		chk(wb, eb);
		$display("conversion mode %0d done", mode);
	endtask

	task automatic t_ref();
		rsel = 1'b0;
		cyc(5);
		chk({13'h0000, iref}, 14'h0000);
		rsel = 1'b1;
		cyc(5);
		chk({13'h0000, iref}, 14'h0001);
		$display("reference select done");
	endtask

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		#2000000;
		err_count++;
		$display("[FAIL] t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
		close_out();
	end

	initial begin
		rst = 1'b1;
		start_n = 1'b1;
		rsel = 1'b1;
		{shi, slo} = 2'h0;
		span_exp = 2'h0;
		pair = 1'b0;
		prev = 1'b0;
		go = 1'b0;
		lv = '{14'h0000, 14'h0000, 14'h0000, 14'h0000};
		err_count = 0;
		tests_run = 0;
		do_reset();
		t_reset();
		for (int i = 0; i < 4; i++) begin
			lv[0] = tv[i];
			lv[1] = ~tv[i];
			lv[2] = tv[i] ^ 14'h0F0F;
			lv[3] = tv[i] + 14'h0001;
			conv(i % 3, i[0], i[1:0], lv[prev], lv[2 + prev]);
			prev = i[0];
		end
		t_ref();
		do_reset();
		t_reset();
		close_out();
	end
endmodule

`default_nettype wire
